// ==== tcs_tx_clock_align.sv ====
// Notes on behaviour
// RULE_01 - The reference clock input times both transmit and receive character rates.
// RULE_02 - Configuration can make the reference clock time the parallel character interface.
// RULE_03 - With the source latch at 0, characters are captured on host input clock rises.
// RULE_04 - The host input clock must match the output clock in frequency, any phase.
// RULE_05 - After centering, host clock wander of half a character is absorbed by the buffer.
// RULE_06 - Buffer overrun or underrun raises the path error and holds it until reinit.
// RULE_07 - Writing 0 to the reinit latch flushes and re-centers the phase-align buffer.
// RULE_08 - The path error clears when the buffer has refilled to its center.
// RULE_09 - The clock output is built from the same ticks as the internal character clock.
// RULE_10 - The clock output runs at reference rate with rate latch 0, twice it with 1.
// RULE_11 - No fixed phase is kept between the clock output and the reference clock.
// RULE_12 - In half-rate reference mode, inputs are sampled on both reference edges.
// RULE_13 - In half-rate reference mode, reference-timed outputs update on both edges.
// RULE_14 - A sent word sync sequence also clears a latched path error.
// RULE_15 - With the source latch at 1, capture uses the reference clock and skips the buffer.
module tcs_tx_clock_align
   import tcs_pkg::*;
#(
   parameter int DEPTH = TCS_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Host side pins, sampled on clk_i
   input wire logic ref_clock_in_i,
   input wire logic host_tx_input_clock_i,
   input wire logic [7:0] tx_char_in_i,
   input wire logic [1:0] tx_char_ctrl_in_i,
   output logic synth_tx_clock_out_o,
   output logic tx_path_error_o,
   // Encoder side
   input wire logic word_sync_sent_i,
   input wire logic enc_ready_i,
   output logic enc_valid_o,
   output logic [7:0] enc_data_o,
   output logic [1:0] enc_ctrl_o
);
   localparam int LW = $clog2(DEPTH) + 1;

   // Configuration latches
   logic [3:0] ctrl_q;
   logic ack_q;
   logic [31:0] rdat_q;

   // Pin history for edge detection
   logic ref_prev_q;
   logic host_prev_q;

   // Capture register
   tcs_char_type cap_q;
   logic cap_vld_q;

   // Alignment state
   tcs_state_type state_q;
   tcs_state_type state_d;
   logic err_q;
   logic err_d;

   // Output character
   tcs_char_type out_q;
   logic out_vld_q;

   // Clock synthesis
   logic clk_out_q;
   logic [TCS_HCNT_W-1:0] hcnt_q;
   logic [TCS_HCNT_W-1:0] meas_q;

   // FIFO wiring
   tcs_char_type fifo_rd_data;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic [LW-1:0] fifo_level;

   // Register decode
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire sel_ctrl = (wb_adr_i == TCS_CTRL_OFS);
   wire sel_stat = (wb_adr_i == TCS_STATUS_OFS);
   wire ctrl_wr = wb_req & wb_we_i & sel_ctrl & wb_sel_i[0];
   wire reinit_req = ctrl_wr & ~wb_dat_i[TCS_CTRL_REINIT_BIT]; // RULE_07

   wire src_ref = ctrl_q[TCS_CTRL_SRC_BIT];
   wire rate_dbl = ctrl_q[TCS_CTRL_RATE_BIT];
   wire half_ref = ctrl_q[TCS_CTRL_HALF_BIT];

   // Edge detection on the sampled clock pins
   wire ref_rise = ref_clock_in_i & ~ref_prev_q;
   wire ref_fall = ~ref_clock_in_i & ref_prev_q;
   wire ref_edge = ref_rise | ref_fall;
   wire host_rise = host_tx_input_clock_i & ~host_prev_q;

   // Internal character tick follows the reference clock
   wire char_tick = ref_rise | (half_ref & ref_fall); // RULE_01 RULE_12 RULE_13

   // Capture clock selection
   wire cap_stb = src_ref ? char_tick : host_rise; // RULE_02 RULE_03 RULE_15

   // Buffer path only in host clock mode
   wire fifo_wr = cap_vld_q & ~src_ref;
   wire overflow = fifo_wr & ~fifo_wr_ready; // RULE_06
   wire drain_try = char_tick & ~src_ref & (state_q == TCS_RUN) & enc_ready_i;
   wire fifo_rd = drain_try & fifo_rd_valid;
   wire underflow = drain_try & ~fifo_rd_valid; // RULE_06
   wire centered = (fifo_level >= LW'(TCS_CENTER_LEVEL));

   wire center_done = (state_q == TCS_FILL) & (state_d == TCS_RUN);

   wire [31:0] stat_word = {24'h000000, src_ref, fifo_level[TCS_LVL_W-1:0],
                            (state_q == TCS_RUN), err_q};
   wire [31:0] rdat_d = sel_ctrl ? {28'h0000000, ctrl_q} :
                        sel_stat ? stat_word : 32'h00000000;

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign tx_path_error_o = err_q;
   assign synth_tx_clock_out_o = clk_out_q;
   assign enc_valid_o = out_vld_q;
   assign enc_data_o = out_q.data;
   assign enc_ctrl_o = out_q.ctrl;

   tcs_fifo #(
      .WIDTH(TCS_CHAR_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(reinit_req), // RULE_07
      .wr_valid_i(fifo_wr),
      .wr_ready_o(fifo_wr_ready),
      .wr_data_i(cap_q),
      .rd_valid_o(fifo_rd_valid),
      .rd_ready_i(fifo_rd),
      .rd_data_o(fifo_rd_data),
      .level_o(fifo_level)
   );

   // Wishbone slave: one wait state, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= wb_req;
         rdat_q <= wb_req ? rdat_d : 32'h00000000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= TCS_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= wb_dat_i[3:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_prev_q <= 1'b0;
         host_prev_q <= 1'b0;
      end else begin
         ref_prev_q <= ref_clock_in_i;
         host_prev_q <= host_tx_input_clock_i;
      end
   end

   // Character capture on the selected interface clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_q <= '0;
         cap_vld_q <= 1'b0;
      end else begin
         cap_vld_q <= cap_stb;
         if (cap_stb) begin
            cap_q <= {tx_char_ctrl_in_i, tx_char_in_i}; // RULE_03 RULE_15
         end
      end
   end

   // Buffer must refill to its center before draining again
   always_comb begin
      state_d = state_q;
      case (state_q)
         TCS_FILL: begin
            if (src_ref || centered) begin
               state_d = TCS_RUN; // RULE_05
            end
         end
         TCS_RUN: begin
            state_d = TCS_RUN;
         end
         default: begin
            state_d = TCS_FILL;
         end
      endcase
      if (reinit_req) begin
         state_d = TCS_FILL; // RULE_07
      end
   end

   // Set wins over clear so a fault on the clearing cycle is kept
   always_comb begin
      err_d = err_q;
      if (center_done || word_sync_sent_i) begin
         err_d = 1'b0; // RULE_08 RULE_14
      end
      if (overflow || underflow) begin
         err_d = 1'b1; // RULE_06
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= TCS_FILL;
         err_q <= 1'b1;
      end else begin
         state_q <= state_d;
         err_q <= err_d;
      end
   end

   // Output to encoder; bypass path ignores enc_ready_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= '0;
         out_vld_q <= 1'b0;
      end else if (src_ref) begin
         out_vld_q <= cap_vld_q; // RULE_15
         if (cap_vld_q) begin
            out_q <= cap_q;
         end
      end else begin
         out_vld_q <= fifo_rd;
         if (fifo_rd) begin
            out_q <= fifo_rd_data;
         end
      end
   end

   // Half-period timer of the reference, used to place the midpoint toggle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hcnt_q <= '0;
         meas_q <= '0;
      end else if (ref_edge) begin
         hcnt_q <= '0;
         meas_q <= hcnt_q;
      end else if (hcnt_q != '1) begin
         hcnt_q <= hcnt_q + 1'b1;
      end
   end

   // Phase follows the sampled reference, not its true edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_out_q <= 1'b0;
      end else if (!rate_dbl) begin
         clk_out_q <= ref_clock_in_i; // RULE_09 RULE_10 RULE_11
      end else if (ref_edge || (hcnt_q == (meas_q >> 1))) begin
         clk_out_q <= ~clk_out_q; // RULE_10
      end
   end

endmodule : tcs_tx_clock_align

// ==== tcs_pkg.sv ====
package tcs_pkg;

   // Wishbone register map, byte addresses
   localparam logic [3:0] TCS_CTRL_OFS = 4'h0;
   localparam logic [3:0] TCS_STATUS_OFS = 4'h4;

   // Control register fields
   localparam int TCS_CTRL_SRC_BIT = 0;
   localparam int TCS_CTRL_RATE_BIT = 1;
   localparam int TCS_CTRL_HALF_BIT = 2;
   localparam int TCS_CTRL_REINIT_BIT = 3;
   localparam logic [3:0] TCS_CTRL_RESET = 4'h8;

   // Status register fields
   localparam int TCS_STAT_ERR_BIT = 0;
   localparam int TCS_STAT_ALIGNED_BIT = 1;
   localparam int TCS_STAT_LVL_LSB = 2;
   localparam int TCS_STAT_SRC_BIT = 7;

   // Phase-align buffer geometry
   localparam int TCS_CHAR_W = 10;
   localparam int TCS_FIFO_DEPTH = 16;
   localparam int TCS_LVL_W = 5;
   localparam logic [4:0] TCS_CENTER_LEVEL = 5'h08;

   // Midpoint timer for the doubled clock output
   localparam int TCS_HCNT_W = 8;

   typedef struct packed {
      logic [1:0] ctrl;
      logic [7:0] data;
   } tcs_char_type;

   typedef enum {
      TCS_FILL,
      TCS_RUN
   } tcs_state_type;

endpackage : tcs_pkg

// ==== tcs_fifo.sv ====
module tcs_fifo
   import tcs_pkg::*;
#(
   parameter int WIDTH = TCS_CHAR_W,
   parameter int DEPTH = TCS_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WIDTH-1:0] wr_data_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WIDTH-1:0] rd_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;

   wire do_wr = wr_valid_i & wr_ready_o;
   wire do_rd = rd_valid_o & rd_ready_i;
   wire [AW:0] used = wr_ptr_q - rd_ptr_q;

   assign wr_ready_o = (used != (AW+1)'(DEPTH));
   assign rd_valid_o = (used != '0);
   assign rd_data_o = mem_q[rd_ptr_q[AW-1:0]];
   assign level_o = used;

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem_q[wr_ptr_q[AW-1:0]] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_q + (AW+1)'(do_wr);
         rd_ptr_q <= rd_ptr_q + (AW+1)'(do_rd);
      end
   end

endmodule : tcs_fifo

// ==== tcs_tx_clock_align_sva.sv ====
module tcs_tx_clock_align_sva
   import tcs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic ref_clock_in_i,
   input wire logic word_sync_sent_i,
   input wire logic enc_valid_o,
   input wire logic synth_tx_clock_out_o,
   input wire logic tx_path_error_o
);
   logic [2:0] cfg_q;
   logic [2:0] ref_q;
   logic [2:0] calm_q;
   logic arm_q;
   logic err_q;
   wire wr = wb_cyc_i & wb_we_i & wb_ack_o & wb_sel_i[0] & (wb_adr_i == TCS_CTRL_OFS);
   wire reinit = wr & ~wb_dat_i[TCS_CTRL_REINIT_BIT];
   wire rise = ref_clock_in_i & ~ref_q[0];
   // Config settled: pipeline no longer mixes old and new modes
   wire calm = calm_q == 3'h7;
   always_ff @(posedge clk_i) begin
      ref_q <= {ref_q[1:0], ref_clock_in_i};
      err_q <= tx_path_error_o;
      calm_q <= (rst_i | wr) ? 3'h0 : calm_q + {2'h0, ~calm};
      arm_q <= rst_i | reinit | word_sync_sent_i | (arm_q & ~(tx_path_error_o & ~err_q));
      if (rst_i)
         cfg_q <= 3'h0;
      else if (wr)
         cfg_q <= wb_dat_i[2:0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; wb_cyc_i & ~wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ref; cfg_q[0] & ~cfg_q[2] & calm & rise |-> ##2 enc_valid_o; endproperty
   a_ref: assert property (p_ref) else $error("ref capture lost");
   property p_half; cfg_q[0] & cfg_q[2] & calm & (ref_clock_in_i ^ ref_q[0]) |-> ##2 enc_valid_o; endproperty
   a_half: assert property (p_half) else $error("half rate capture lost");
   property p_only; cfg_q[0] & calm & enc_valid_o |-> (ref_q[1] ^ ref_q[2]) & (ref_q[1] | cfg_q[2]); endproperty
   a_only: assert property (p_only) else $error("spurious character");
   property p_rate0; ~cfg_q[1] & calm & rise |-> ##[1:2] $rose(synth_tx_clock_out_o); endproperty
   a_rate0: assert property (p_rate0) else $error("clock out lost");
   property p_hold; $fell(tx_path_error_o) |-> arm_q; endproperty
   a_hold: assert property (p_hold) else $error("error dropped early");
   property p_sync; cfg_q[0] & calm & word_sync_sent_i |=> ~tx_path_error_o; endproperty
   a_sync: assert property (p_sync) else $error("sync left error");
   property p_reinit; reinit & cfg_q[0] & wb_dat_i[0] |-> ##[1:2] ~tx_path_error_o; endproperty
   a_reinit: assert property (p_reinit) else $error("reinit left error");
endmodule : tcs_tx_clock_align_sva

bind tcs_tx_clock_align tcs_tx_clock_align_sva u_sva (.*);

// ==== tcs_host_model.sv ====
module tcs_host_model
   import tcs_pkg::*;
(
   input wire logic clk_i,
   input wire logic ref_i,
   input wire logic use_ref_i,
   input wire logic [3:0] half_i,
   output logic host_clk_o,
   output tcs_char_type char_o
);
   logic [3:0] cnt_q = 4'h0;
   logic [1:0] dly_q = 2'h0;
   logic ref_q = 1'b0;
   logic hc_q = 1'b0;
   logic [9:0] ch_q = 10'h000;
   wire flip = cnt_q >= half_i;
   assign host_clk_o = hc_q;
   assign char_o = ch_q;
   always @(posedge clk_i) begin
      ref_q <= ref_i;
      cnt_q <= flip ? 4'h0 : cnt_q + 4'h1;
      if (flip)
         hc_q <= ~hc_q;
      dly_q <= {dly_q[0], use_ref_i ? ref_i ^ ref_q : flip};
      // Data moves mid-period so no capture edge sees it change
      if (dly_q[1])
         ch_q <= 10'($urandom);
   end
endmodule : tcs_host_model

// ==== tcs_tx_clock_align_tb_top.sv ====
module tcs_tx_clock_align_tb_top
   import tcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 0, we = 0, ref_c = 0, sync = 0, rdy = 1, src = 0, rate = 0, half = 0, sk = 1;
   logic h_q = 0, r_q = 0, ack, sck, err, ev, hclk;
   logic [3:0] adr = 4'h0, hh = 4'h3;
   logic [31:0] wd = 32'h0, rd, rdat;
   logic [7:0] ed;
   logic [1:0] ec;
   tcs_char_type ch;
   tcs_char_type exp_q[$];
   int mismatches = 0, total_checks = 0, rc = 0;
   always #2.5 clk_i = ~clk_i;
   tcs_host_model host (.clk_i(clk_i), .ref_i(ref_c), .use_ref_i(src), .half_i(hh),
      .host_clk_o(hclk), .char_o(ch));
   tcs_tx_clock_align #(.DEPTH(TCS_FIFO_DEPTH)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .ref_clock_in_i(ref_c),
      .host_tx_input_clock_i(hclk), .tx_char_in_i(ch.data), .tx_char_ctrl_in_i(ch.ctrl),
      .synth_tx_clock_out_o(sck), .tx_path_error_o(err), .word_sync_sent_i(sync),
      .enc_ready_i(rdy), .enc_valid_o(ev), .enc_data_o(ed), .enc_ctrl_o(ec));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, want, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check("ack", 32'(ack), 1);
      if (n >= 20)
         complete_run();
      rd = rdat;
      if (w && a == TCS_CTRL_OFS)
         {half, rate, src} <= d[2:0];
      cyc <= 0;
      sk <= 1;
   endtask : bus
   task automatic wait_err(input logic v);
      int n;
      for (n = 0; err !== v && n < 400; n++)
         @(posedge clk_i);
      check("path error", 32'(err), 32'(v));
      if (n >= 400)
         complete_run();
   endtask : wait_err
   task automatic rates(input int mul);
      int r, s;
      logic rp, sp;
      r = 0;
      s = 0;
      repeat (16) @(posedge clk_i);
      rp = ref_c;
      sp = sck;
      repeat (80) begin
         @(posedge clk_i);
         r += int'(ref_c & ~rp);
         s += int'(sck & ~sp);
         rp = ref_c;
         sp = sck;
      end
      check("clock out rises", s, r * mul);
   endtask : rates
   always @(posedge clk_i) begin
      rc <= (rc == 3) ? 0 : rc + 1;
      if (rc == 3)
         ref_c <= ~ref_c;
      h_q <= hclk;
      r_q <= ref_c;
      if (!rst_i && (src ? (ref_c & ~r_q) | (half & r_q & ~ref_c) : hclk & ~h_q))
         exp_q.push_back(ch);
      if (!rst_i && ev) begin
         // Flushes and mode changes leave stale entries in front
         while (sk && exp_q.size() > 1 && exp_q[0] !== {ec, ed})
            void'(exp_q.pop_front());
         sk <= 0;
         check("char", 32'({ec, ed}),
               exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'h400);
      end
   end
   initial begin
      void'($urandom(80862));
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      check("reset error", 32'(err), 1);
      bus(0, TCS_CTRL_OFS, 0);
      check("ctrl reset", rd, 32'(TCS_CTRL_RESET));
      bus(0, 4'hC, 0);
      check("unmapped", rd, 0);
      bus(1, TCS_CTRL_OFS, 0);
      wait_err(0);
      repeat (150) begin
         @(posedge clk_i);
         rdy <= ($urandom % 16) != 0;
      end
      rdy <= 1;
      check("wander error", 32'(err), 0);
      // Level moves with the drain, so only error, aligned and source are compared
      bus(0, TCS_STATUS_OFS, 0);
      check("status", rd & 32'h83, 32'(1) << TCS_STAT_ALIGNED_BIT);
      rates(1);
      bus(1, TCS_CTRL_OFS, 32'hA);
      rates(2);
      rdy <= 0;
      wait_err(1);
      repeat (40) @(posedge clk_i);
      check("error held", 32'(err), 1);
      bus(1, TCS_CTRL_OFS, 0);
      rdy <= 1;
      wait_err(0);
      hh <= 4'hF;
      wait_err(1);
      hh <= 4'h3;
      bus(1, TCS_CTRL_OFS, 32'h9);
      repeat (60) @(posedge clk_i);
      check("ref mode error", 32'(err), 1);
      sync <= 1;
      @(posedge clk_i);
      sync <= 0;
      @(posedge clk_i);
      check("sync clear", 32'(err), 0);
      bus(1, TCS_CTRL_OFS, 32'hD);
      repeat (60) @(posedge clk_i);
      bus(1, TCS_CTRL_OFS, 32'h5);
      wait_err(0);
      complete_run();
   end
endmodule : tcs_tx_clock_align_tb_top
